// >>> src/csel_pkg.sv
package csel_pkg;

    // register byte offsets
    localparam logic [7:0] SYSTEM_CLOCK_CONFIG_OFS = 8'h00;
    localparam logic [7:0] PLL_CONFIG_OFS = 8'h04;
    localparam logic [7:0] PRESCALER_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;

    // field widths
    localparam int K1_W = 10;
    localparam int P_W = 4;
    localparam int N_W = 7;
    localparam int K2_W = 7;
    localparam int H_W = 7;
    localparam int ERR_W = 4;
    localparam int LOCK_W = 4;
    localparam int PARK_W = 2;

    // field positions inside pll_config
    localparam int PLL_BYPASS_POS = 0;
    localparam int PLL_REF_POS = 1;
    localparam int PLL_BAND_POS = 2;
    localparam int PLL_PLL_INPUT_DIVIDE_FIELD_POS = 4;
    localparam int PLL_PLL_FEEDBACK_FIELD_POS = 8;
    localparam int PLL_K2_POS = 16;

    // field positions inside status
    localparam int ST_SEL_POS = 0;
    localparam int ST_LOCK_POS = 2;
    localparam int ST_SWITCH_POS = 3;
    localparam int ST_BYPASS_POS = 4;

    // source select codes
    localparam logic [1:0] SEL_WAKEUP = 2'h0;
    localparam logic [1:0] SEL_PLL_PRESC = 2'h2;
    localparam logic [1:0] SEL_DIRECT = 2'h3;

    // reset values
    localparam logic [1:0] SEL_RST = SEL_WAKEUP;
    localparam logic BYPASS_RST = 1'b1;

    // input index in the synchronised source vector
    localparam int SRC_DIRECT = 0;
    localparam int SRC_CRYSTAL = 1;
    localparam int SRC_ONCHIP = 2;
    localparam int SRC_WAKEUP = 3;

    // vco half-period limits in mclk cycles, per band
    localparam logic [H_W-1:0] BAND0_HALF_MIN = 7'h02;
    localparam logic [H_W-1:0] BAND0_HALF_MAX = 7'h40;
    localparam logic [H_W-1:0] BAND1_HALF_MIN = 7'h01;
    localparam logic [H_W-1:0] BAND1_HALF_MAX = 7'h20;

    // park length in mclk cycles, lock count in reference pulses
    localparam logic [PARK_W-1:0] PARK_CYCLES = 2'h2;
    localparam logic [LOCK_W-1:0] LOCK_PULSES = 4'hF;

    typedef enum logic [0:0] {
        SW_RUN = 1'b0,
        SW_PARK = 1'b1
    } csel_sw_t;

    typedef struct packed {
        logic [1:0] sel;
        logic bypass;
        logic ref_sel;
        logic [1:0] band;
        logic [P_W-1:0] pll_input_divide_field;
        logic [N_W-1:0] pll_feedback_field;
        logic [K2_W-1:0] vco_output_divide_field;
        logic [K1_W-1:0] prescaler_divide_field;
    } csel_cfg_t;

    typedef struct packed {
        csel_cfg_t cfg;
        csel_cfg_t act;
        csel_sw_t sw;
        logic [PARK_W-1:0] park_cnt;
        logic ack;
        logic [31:0] rdat;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [K1_W-1:0] k1_cnt;
        logic pre_lvl;
        logic [P_W-1:0] pref_cnt;
        logic vco_lvl;
        logic [H_W-1:0] vco_cnt;
        logic [H_W-1:0] vco_half;
        logic [N_W-1:0] fb_cnt;
        logic [K2_W-1:0] k2_cnt;
        logic k2_lvl;
        logic signed [ERR_W-1:0] err;
        logic [LOCK_W-1:0] lock_cnt;
        logic sysclk;
    } csel_state_t;

endpackage

// >>> src/csel_clock_select.sv
// What this block does
// RULE1: select 11 drives system clock from direct input
// RULE2: select 10, bypass set: source divided by prescaler
// RULE3: prescaler divides by up to 1024
// RULE4: prescaler factor 1 passes source unchanged
// RULE5: select 10, bypass clear: PLL runs, clocks system
// RULE6: PLL ratio is N over P times K2
// RULE7: PLL reference from crystal or on-chip source
// RULE8: PLL frequency slews gradually, never jumps
// RULE9: system clock is VCO divided by K2
// RULE10: band 00 and 01 set VCO range
// RULE11: select 00 runs from wakeup clock
// RULE12: software writes fields in a safe order
// RULE13: software changes frequency in small steps
// RULE14: crystal bypass with factor 1 acts like direct
// RULE15: source switches never truncate clock pulses; the new source's first high phase after the hold can be cut short
`timescale 1ns/1ps
`default_nettype none

module csel_clock_select (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic direct_clock_input_in,
    input wire logic crystal_input_in,
    input wire logic onchip_clock_in,
    input wire logic wakeup_clock_in,
    output logic sysclk_out,
    output logic pll_locked_out
);

    csel_pkg::csel_state_t st_ff;
    csel_pkg::csel_state_t nxt_st;

    function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [31:0] pll_word(input csel_pkg::csel_cfg_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[csel_pkg::PLL_BYPASS_POS] = c.bypass;
        w[csel_pkg::PLL_REF_POS] = c.ref_sel;
        w[csel_pkg::PLL_BAND_POS +: 2] = c.band;
        w[csel_pkg::PLL_PLL_INPUT_DIVIDE_FIELD_POS +: csel_pkg::P_W] = c.pll_input_divide_field;
        w[csel_pkg::PLL_PLL_FEEDBACK_FIELD_POS +: csel_pkg::N_W] = c.pll_feedback_field;
        w[csel_pkg::PLL_K2_POS +: csel_pkg::K2_W] = c.vco_output_divide_field;
        return w;
    endfunction

    // high phase length of a divide-by-(field+1): ceil of half
    function automatic logic [csel_pkg::K1_W:0] high_len(input logic [csel_pkg::K1_W-1:0] f);
        return ({1'b0, f} + 11'h002) >> 1;
    endfunction

    function automatic logic [csel_pkg::H_W-1:0] half_lim(input logic [1:0] band,
                                                          input logic want_max);
        logic [csel_pkg::H_W-1:0] v;
        if (band == 2'h1) begin
            v = want_max ? csel_pkg::BAND1_HALF_MAX : csel_pkg::BAND1_HALF_MIN;
        end else begin
            v = want_max ? csel_pkg::BAND0_HALF_MAX : csel_pkg::BAND0_HALF_MIN;
        end
        return v;
    endfunction

    logic [3:0] src_rise;
    logic ref_lvl;
    logic ref_rise;
    logic pll_mode;
    logic presc_mode;
    logic hit;
    logic [31:0] cfg_word;
    logic [31:0] pll_w;
    logic [31:0] presc_w;

    always_comb begin
        nxt_st = st_ff;

        // two-stage synchronisers, edges taken from the second stage only
        nxt_st.sync1 = {wakeup_clock_in, onchip_clock_in, crystal_input_in, direct_clock_input_in};
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.prev = st_ff.sync2;
        src_rise = st_ff.sync2 & ~st_ff.prev;

        // wishbone slave, one wait state, unmapped reads zero and writes drop
        hit = wb_cyc_in && wb_stb_in && !st_ff.ack;
        nxt_st.ack = hit;
        cfg_word = {30'h0000_0000, st_ff.cfg.sel};
        pll_w = pll_word(st_ff.cfg);
        presc_w = {22'h00_0000, st_ff.cfg.prescaler_divide_field};
        nxt_st.rdat = 32'h0000_0000;
        if (hit && !wb_we_in) begin
            case (wb_adr_in)
                csel_pkg::SYSTEM_CLOCK_CONFIG_OFS: nxt_st.rdat = cfg_word;
                csel_pkg::PLL_CONFIG_OFS: nxt_st.rdat = pll_w;
                csel_pkg::PRESCALER_OFS: nxt_st.rdat = presc_w;
                csel_pkg::STATUS_OFS: begin
                    nxt_st.rdat[csel_pkg::ST_SEL_POS +: 2] = st_ff.act.sel;
                    nxt_st.rdat[csel_pkg::ST_LOCK_POS] = (st_ff.lock_cnt == csel_pkg::LOCK_PULSES);
                    nxt_st.rdat[csel_pkg::ST_SWITCH_POS] = (st_ff.sw == csel_pkg::SW_PARK)
                        || (st_ff.cfg != st_ff.act);
                    nxt_st.rdat[csel_pkg::ST_BYPASS_POS] = st_ff.act.bypass;
                end
                default: nxt_st.rdat = 32'h0000_0000;
            endcase
        end
        if (hit && wb_we_in) begin
            case (wb_adr_in)
                csel_pkg::SYSTEM_CLOCK_CONFIG_OFS: begin
                    cfg_word = merge(cfg_word, wb_dat_in, wb_sel_in);
                    nxt_st.cfg.sel = cfg_word[1:0];
                end
                csel_pkg::PLL_CONFIG_OFS: begin
                    pll_w = merge(pll_w, wb_dat_in, wb_sel_in);
                    nxt_st.cfg.bypass = pll_w[csel_pkg::PLL_BYPASS_POS];
                    nxt_st.cfg.ref_sel = pll_w[csel_pkg::PLL_REF_POS];
                    nxt_st.cfg.band = pll_w[csel_pkg::PLL_BAND_POS +: 2];
                    nxt_st.cfg.pll_input_divide_field = pll_w[csel_pkg::PLL_PLL_INPUT_DIVIDE_FIELD_POS +: csel_pkg::P_W];
                    nxt_st.cfg.pll_feedback_field = pll_w[csel_pkg::PLL_PLL_FEEDBACK_FIELD_POS +: csel_pkg::N_W];
                    nxt_st.cfg.vco_output_divide_field = pll_w[csel_pkg::PLL_K2_POS +: csel_pkg::K2_W];
                end
                csel_pkg::PRESCALER_OFS: begin
                    presc_w = merge(presc_w, wb_dat_in, wb_sel_in);
                    nxt_st.cfg.prescaler_divide_field = presc_w[csel_pkg::K1_W-1:0];
                end
                default: ;
            endcase
        end

        // reference for prescaler and pll: crystal or on-chip source
        ref_lvl = st_ff.act.ref_sel ? st_ff.sync2[csel_pkg::SRC_ONCHIP]
                                    : st_ff.sync2[csel_pkg::SRC_CRYSTAL]; // RULE7
        ref_rise = st_ff.act.ref_sel ? src_rise[csel_pkg::SRC_ONCHIP]
                                     : src_rise[csel_pkg::SRC_CRYSTAL];
        presc_mode = (st_ff.act.sel == csel_pkg::SEL_PLL_PRESC) && st_ff.act.bypass;
        pll_mode = (st_ff.act.sel == csel_pkg::SEL_PLL_PRESC) && !st_ff.act.bypass; // RULE5

        // output prescaler K1 = field+1, up to 1024
        if (ref_rise) begin
            nxt_st.k1_cnt = (st_ff.k1_cnt >= st_ff.act.prescaler_divide_field) ? '0
                : st_ff.k1_cnt + 10'h001; // RULE3
            nxt_st.pre_lvl = ({1'b0, nxt_st.k1_cnt} < high_len(st_ff.act.prescaler_divide_field)); // RULE2
        end

        // pll model: vco is a half-period counter steered by a frequency detector
        if (pll_mode) begin
            logic fb_pulse;
            logic ref_pulse;
            logic vco_rise;
            fb_pulse = 1'b0;
            ref_pulse = 1'b0;
            vco_rise = 1'b0;
            if (st_ff.vco_cnt >= st_ff.vco_half - 7'h01) begin
                nxt_st.vco_cnt = '0;
                nxt_st.vco_lvl = !st_ff.vco_lvl;
                vco_rise = !st_ff.vco_lvl;
            end else begin
                nxt_st.vco_cnt = st_ff.vco_cnt + 7'h01;
            end
            if (ref_rise) begin
                ref_pulse = (st_ff.pref_cnt >= st_ff.act.pll_input_divide_field);
                nxt_st.pref_cnt = ref_pulse ? '0 : st_ff.pref_cnt + 4'h1; // RULE6
            end
            if (vco_rise) begin
                fb_pulse = (st_ff.fb_cnt >= st_ff.act.pll_feedback_field);
                nxt_st.fb_cnt = fb_pulse ? '0 : st_ff.fb_cnt + 7'h01; // RULE6
                // system clock is the vco divided by K2
                nxt_st.k2_cnt = (st_ff.k2_cnt >= st_ff.act.vco_output_divide_field) ? '0
                    : st_ff.k2_cnt + 7'h01; // RULE9
                nxt_st.k2_lvl = ({4'h0, nxt_st.k2_cnt}
                    < high_len({3'h0, st_ff.act.vco_output_divide_field})); // RULE9
            end
            // error counts one reference window only, so it returns to zero once
            // the rates match even with the vco parked at a band limit
            if (ref_pulse) begin
                nxt_st.err = fb_pulse ? 4'sd0 : 4'sd1;
            end else if (fb_pulse && st_ff.err != -4'sd8) begin
                nxt_st.err = st_ff.err - 4'sd1;
            end
            // one step of half period per reference pulse, so no frequency jump
            if (ref_pulse) begin
                if (st_ff.err > 4'sd0 && st_ff.vco_half > half_lim(st_ff.act.band, 1'b0)) begin
                    nxt_st.vco_half = st_ff.vco_half - 7'h01; // RULE8
                end else if (st_ff.err < 4'sd0
                             && st_ff.vco_half < half_lim(st_ff.act.band, 1'b1)) begin
                    nxt_st.vco_half = st_ff.vco_half + 7'h01; // RULE8
                end
                if (st_ff.err == 4'sd0) begin
                    if (st_ff.lock_cnt != csel_pkg::LOCK_PULSES) begin
                        nxt_st.lock_cnt = st_ff.lock_cnt + 4'h1;
                    end
                end else begin
                    nxt_st.lock_cnt = '0;
                end
            end
        end else begin
            nxt_st.vco_half = half_lim(st_ff.act.band, 1'b1); // RULE10
            nxt_st.vco_cnt = '0;
            nxt_st.vco_lvl = 1'b0;
            nxt_st.err = '0;
            nxt_st.lock_cnt = '0;
            nxt_st.pref_cnt = '0;
            nxt_st.fb_cnt = '0;
        end

        // output mux
        case (st_ff.act.sel)
            csel_pkg::SEL_DIRECT: nxt_st.sysclk = st_ff.sync2[csel_pkg::SRC_DIRECT]; // RULE1
            csel_pkg::SEL_PLL_PRESC: begin
                if (presc_mode) begin
                    // factor 1 follows the source level, so duty cycle is kept
                    nxt_st.sysclk = (st_ff.act.prescaler_divide_field == '0) ? ref_lvl // RULE4 RULE14
                                                            : nxt_st.pre_lvl; // RULE2
                end else begin
                    nxt_st.sysclk = (st_ff.act.vco_output_divide_field == '0) ? nxt_st.vco_lvl
                                                            : nxt_st.k2_lvl; // RULE9
                end
            end
            default: nxt_st.sysclk = st_ff.sync2[csel_pkg::SRC_WAKEUP]; // RULE11
        endcase

        // switch only while the output is low, then hold low before the new source
        case (st_ff.sw)
            csel_pkg::SW_RUN: begin
                if (st_ff.cfg != st_ff.act && !st_ff.sysclk) begin
                    nxt_st.sw = csel_pkg::SW_PARK; // RULE15
                    nxt_st.act = st_ff.cfg;
                    nxt_st.park_cnt = '0;
                    nxt_st.sysclk = 1'b0;
                    nxt_st.k1_cnt = '0;
                    nxt_st.pre_lvl = 1'b1;
                    nxt_st.k2_cnt = '0;
                    nxt_st.k2_lvl = 1'b1;
                    // a new ratio must earn its own lock
                    nxt_st.lock_cnt = '0;
                end
            end
            csel_pkg::SW_PARK: begin
                nxt_st.sysclk = 1'b0; // RULE15
                nxt_st.park_cnt = st_ff.park_cnt + 2'h1;
                if (st_ff.park_cnt >= csel_pkg::PARK_CYCLES - 2'h1) begin
                    nxt_st.sw = csel_pkg::SW_RUN;
                end
            end
            default: nxt_st.sw = csel_pkg::SW_RUN;
        endcase
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_ff <= '0;
            st_ff.cfg.sel <= csel_pkg::SEL_RST;
            st_ff.cfg.bypass <= csel_pkg::BYPASS_RST;
            st_ff.act.sel <= csel_pkg::SEL_RST;
            st_ff.act.bypass <= csel_pkg::BYPASS_RST;
            st_ff.vco_half <= csel_pkg::BAND0_HALF_MAX;
            st_ff.sw <= csel_pkg::SW_RUN;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_ack_out = st_ff.ack;
    assign wb_dat_out = st_ff.rdat;
    assign sysclk_out = st_ff.sysclk;
    assign pll_locked_out = (st_ff.lock_cnt == csel_pkg::LOCK_PULSES);

endmodule

`default_nettype wire

// >>> verif/csel_clock_select_checker.sv
`timescale 1ns/1ps
`default_nettype none
module csel_clock_select_checker (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic wb_ack_out,
    input wire logic direct_clock_input_in,
    input wire logic crystal_input_in,
    input wire logic onchip_clock_in,
    input wire logic wakeup_clock_in,
    input wire logic sysclk_out,
    input wire logic pll_locked_out
);
    logic [1:0] sel_ff;
    logic byp_ff;
    logic [5:0] age_ff;
    logic wr, settled;
    assign wr = wb_ack_out && wb_we_in && wb_sel_in[0];
    // switching waits for a low phase, so only judge well after a write
    assign settled = (age_ff == 6'h3F);
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sel_ff <= csel_pkg::SEL_RST;
            byp_ff <= csel_pkg::BYPASS_RST;
            age_ff <= 6'h00;
        end else begin
            if (wr && wb_adr_in == csel_pkg::SYSTEM_CLOCK_CONFIG_OFS) begin
                sel_ff <= wb_dat_in[1:0];
            end
            if (wr && wb_adr_in == csel_pkg::PLL_CONFIG_OFS) begin
                byp_ff <= wb_dat_in[0];
            end
            age_ff <= wr ? 6'h00 : (settled ? age_ff : age_ff + 6'h01);
        end
    end

    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);

    a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack stood longer than one cycle");
    a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("request not answered in the next cycle");
    a_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without a request");
    a_rdat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
        else $error("read data not zero outside ack");
    a_rdat_write: assert property (wb_ack_out && wb_we_in |-> wb_dat_out == 32'h0000_0000)
        else $error("read data not zero on write ack");
    a_direct_follow: assert property (settled && sel_ff == csel_pkg::SEL_DIRECT
        |-> sysclk_out == $past(direct_clock_input_in, 3))
        else $error("system clock does not follow direct input");
    a_wakeup_follow: assert property (settled && !sel_ff[1]
        |-> sysclk_out == $past(wakeup_clock_in, 3))
        else $error("system clock does not follow wakeup source");
    a_lock_mode: assert property (settled && !(sel_ff == 2'h2 && !byp_ff)
        |-> !pll_locked_out)
        else $error("locked while loop not selected");

    c_direct: cover property (settled && sel_ff == 2'h3 && $rose(sysclk_out));
    c_presc: cover property (settled && sel_ff == 2'h2 && byp_ff && $rose(sysclk_out));
    c_lock: cover property ($rose(pll_locked_out));
endmodule

bind csel_clock_select csel_clock_select_checker i_csel_clock_select_checker (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .direct_clock_input_in(direct_clock_input_in), .crystal_input_in(crystal_input_in),
    .onchip_clock_in(onchip_clock_in), .wakeup_clock_in(wakeup_clock_in),
    .sysclk_out(sysclk_out), .pll_locked_out(pll_locked_out)
);
`default_nettype wire

// >>> verif/csel_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// oscillators run free; a 7 ns start offset keeps their edges off the mclk edges while each half period is a multiple of 50 ns
module csel_src_model #(
    parameter int DIRECT_HALF = 300,
    parameter int CRYSTAL_HALF = 200,
    parameter int ONCHIP_HALF = 250,
    parameter int WAKEUP_HALF = 500
) (
    output var logic direct_out,
    output var logic crystal_out,
    output var logic onchip_out,
    output var logic wakeup_out
);
    initial begin
        direct_out = 1'b0;
        crystal_out = 1'b0;
        onchip_out = 1'b0;
        wakeup_out = 1'b0;
        #7;
        fork
            forever #(DIRECT_HALF) direct_out = ~direct_out;
            forever #(CRYSTAL_HALF) crystal_out = ~crystal_out;
            forever #(ONCHIP_HALF) onchip_out = ~onchip_out;
            forever #(WAKEUP_HALF) wakeup_out = ~wakeup_out;
        join
    end
endmodule
`default_nettype wire

// >>> verif/csel_clock_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module csel_clock_select_tb;
    logic mclk_in = 1'b0;
    logic resetn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack, sysclk, locked, dclk, xclk, oclk, uclk;
    int mismatches = 0;
    int compares = 0;

    always #50 mclk_in = ~mclk_in;

    csel_src_model #(.DIRECT_HALF(337), .CRYSTAL_HALF(200), .ONCHIP_HALF(250),
        .WAKEUP_HALF(500)) i_csel_src_model (
        .direct_out(dclk), .crystal_out(xclk), .onchip_out(oclk), .wakeup_out(uclk)
    );
    csel_clock_select i_csel_clock_select (
        .mclk_in(mclk_in), .resetn_in(resetn), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
        .wb_dat_out(rdat), .wb_ack_out(ack), .direct_clock_input_in(dclk),
        .crystal_input_in(xclk), .onchip_clock_in(oclk), .wakeup_clock_in(uclk),
        .sysclk_out(sysclk), .pll_locked_out(locked)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        @(posedge mclk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        n = 0;
        do begin
            @(posedge mclk_in);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk({31'h0, ack}, 32'h0000_0001);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0000_0000, q);
        chk(q, e);
    endtask

    task automatic wait_lvl(input logic v);
        int n;
        n = 0;
        while (sysclk !== v && n < 20000) begin
            @(posedge mclk_in);
            n++;
        end
    endtask

    // two rising edges of the output first, so the switch has surely taken place
    task automatic mode_chk(input int pe, input int he, input int tol);
        int per, hi;
        repeat (2) begin
            wait_lvl(1'b0);
            wait_lvl(1'b1);
        end
        hi = 0;
        while (sysclk === 1'b1 && hi < 20000) begin
            @(posedge mclk_in);
            hi++;
        end
        per = hi;
        while (sysclk === 1'b0 && per < 20000) begin
            @(posedge mclk_in);
            per++;
        end
        chk(32'((per >= pe - tol && per <= pe + tol) ? pe : per), 32'(pe));
        if (he >= 0) begin
            chk(32'(hi), 32'(he));
        end
    endtask

    task automatic wait_lock();
        int n;
        n = 0;
        repeat (20) @(posedge mclk_in);
        while (locked !== 1'b1 && n < 8000) begin
            @(posedge mclk_in);
            n++;
        end
        chk({31'h0, locked}, 32'h0000_0001);
    endtask

    task automatic t_regs();
        rd(8'h00, 32'h0000_0000);
        rd(8'h04, 32'h0000_0001);
        rd(8'h08, 32'h0000_0000);
        rd(8'h0C, 32'h0000_0010);
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C, 32'h0000_0010);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, 32'h0000_0000);
        $display("test regs done");
    endtask

    task automatic t_direct();
        mode_chk(10, 5, 0);
        wr(8'h00, 32'h0000_0003);
        mode_chk(7, -1, 1);
        rd(8'h0C, 32'h0000_0013);
        $display("test direct done");
    endtask

    task automatic t_presc();
        wr(8'h08, 32'h0000_0000);
        wr(8'h00, 32'h0000_0002);
        mode_chk(4, 2, 0);
        wr(8'h08, 32'h0000_0002);
        mode_chk(12, 8, 0);
        wr(8'h04, 32'h0000_0003);
        mode_chk(15, 10, 0);
        wr(8'h04, 32'h0000_0001);
        wr(8'h08, 32'h0000_03FF);
        mode_chk(4096, 2048, 0);
        $display("test prescaler done");
    endtask

    task automatic t_pll();
        wr(8'h04, 32'h0001_0000);
        wait_lock();
        rd(8'h0C, 32'h0000_0006);
        mode_chk(8, -1, 1);
        wr(8'h04, 32'h0001_0104);
        wait_lock();
        mode_chk(4, -1, 1);
        wr(8'h00, 32'h0000_0000);
        repeat (100) @(posedge mclk_in);
        chk({31'h0, locked}, 32'h0000_0000);
        $display("test pll done");
    endtask

    initial begin
        repeat (60000) @(posedge mclk_in);
        mismatches++;
        summarize();
    end

    initial begin
        repeat (4) @(posedge mclk_in);
        resetn <= 1'b1;
        t_regs();
        t_direct();
        t_presc();
        t_pll();
        summarize();
    end
endmodule
`default_nettype wire
